// ==== dsbd_decoder.sv ====
// Data space and program space decoder of an 8-bit core.
// Assumes core, ROM, RAM, EEPROM and OSD all on clock_i; memories
// return read data combinationally while mem_o selects them.
`timescale 1ns/100ps
`include "dsbd_regs.svh"
module dsbd_decoder #(
    parameter bit LARGE_EEP = 1'b1
) (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    input  wire dsbd_pkg::dsbd_req_t req_i,
    input  wire logic                fetch_valid_i,
    input  wire logic [11:0]         pc_i,
    input  wire logic [7:0]          mem_rdata_i,
    output dsbd_pkg::dsbd_mem_t      mem_o,
    output dsbd_pkg::dsbd_rsp_t      rsp_o,
    output dsbd_pkg::dsbd_fetch_t    fetch_o
);
    import dsbd_pkg::*;

    // ****************************************
    // Bank decoding
    // ****************************************
    // Several bits set: EEPROM first, then lowest RAM, then OSD.
    // Software should never rely on that order.
    function automatic logic [5:0] bank_decode(input logic [7:0] b);
        logic [1:0] ep;
        ep = b[1:0];
        bank_decode = {3'd0, 3'd0};
        // R12 EEPROM page code
        if (ep != 2'b00 && !(b[`DSBD_BK_EEP_HI] && !LARGE_EEP)) begin
            bank_decode = {3'd2, 3'(ep - 2'd1)
                          + (b[`DSBD_BK_EEP_HI] ? 3'd3 : 3'd0)};
        // R13 RAM page bits
        end else if (b[`DSBD_BK_RAM2]) begin
            bank_decode = {3'd1, 3'd1};
        end else if (b[`DSBD_BK_RAM3]) begin
            bank_decode = {3'd1, 3'd2};
        end else if (b[`DSBD_BK_RAM4]) begin
            bank_decode = {3'd1, 3'd3};
        // R14 OSD page bits
        end else if (b[`DSBD_BK_OSD5]) begin
            bank_decode = {3'd3, 3'd0};
        end else if (b[`DSBD_BK_OSD6]) begin
            bank_decode = {3'd3, 3'd1};
        end
    endfunction : bank_decode

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]   win_q;
    logic [7:0]   bank_q;
    logic [4:0]   page_q;
    dsbd_mem_t    mem_q;
    dsbd_mem_t    mem_d;
    dsbd_rsp_t    rsp_q;
    logic         rd_pend_q;
    dsbd_fetch_t  fetch_q;
    dsbd_fetch_t  fetch_map;

    // ****************************************
    // Request decode
    // ****************************************
    wire logic [7:0] a       = req_i.addr;
    wire logic [5:0] low6    = a[5:0];
    wire logic       taken   = req_i.valid;
    // R16 whole-byte writes only
    wire logic       byte_wr = taken && req_i.write && !req_i.bitop;
    wire logic       hit_win  = (a == `DSBD_WIN_ADDR);
    wire logic       hit_bank = (a == `DSBD_BANK_ADDR);
    wire logic       hit_page = (a == `DSBD_PAGE_ADDR);
    wire logic       hit_reg  = hit_win || hit_bank || hit_page;
    wire logic [5:0] bank_sel = bank_decode(bank_q);
    wire logic [2:0] bank_tgt = bank_sel[5:3];
    wire logic [2:0] bank_idx = bank_sel[2:0];
    // R4 one unified data space
    wire logic       rgn_bank = (a[7:6] == `DSBD_RGN_BANK);
    wire logic       rgn_win  = (a[7:6] == `DSBD_RGN_WIN);
    wire logic       rgn_ram  = (a[7:6] == `DSBD_RGN_RAM);
    // R5 R6 R9 window address, 14 bits caps it at 16K
    wire logic [13:0] win_addr = {win_q, low6};
    // R10 direct RAM is physical page 0
    wire logic [13:0] ram_addr = {6'd0, 2'd0, low6};
    // R11 banked address
    wire logic [13:0] bnk_addr = {5'd0, bank_idx, low6};

    always_comb begin
        mem_d        = '0;
        mem_d.target = DSBD_TGT_NONE;
        mem_d.wdata  = req_i.wdata;
        if (taken) begin
            if (rgn_bank) begin
                // R11 R18 bank target or nothing
                mem_d.target = dsbd_target_t'(bank_tgt);
                mem_d.addr   = bnk_addr;
                mem_d.we     = req_i.write && (bank_tgt != 3'd0);
            end else if (rgn_win) begin
                // R5 window is read only
                mem_d.target = DSBD_TGT_ROM;
                mem_d.addr   = win_addr;
            end else if (rgn_ram) begin
                mem_d.target = DSBD_TGT_RAM;
                mem_d.addr   = ram_addr;
                mem_d.we     = req_i.write;
            end else if (hit_reg) begin
                mem_d.target = DSBD_TGT_REG;
                mem_d.we     = byte_wr;
            end else begin
                mem_d.target = DSBD_TGT_PER;
                mem_d.addr   = {6'd0, a};
                mem_d.we     = req_i.write;
            end
        end
    end

    // ****************************************
    // Write-only registers
    // ****************************************
    // Held undefined by the core's view; reset here only to stay clean.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            win_q  <= `DSBD_WIN_RST;
            bank_q <= `DSBD_BANK_RST;
            page_q <= `DSBD_PAGE_RST;
        end else begin
            // R7 R8 window write
            if (byte_wr && hit_win) begin
                win_q <= req_i.wdata;
            end
            // R11 bank write
            if (byte_wr && hit_bank) begin
                bank_q <= req_i.wdata;
            end
            // R17 page write
            if (byte_wr && hit_page) begin
                page_q <= req_i.wdata[4:0];
            end
        end
    end

    // ****************************************
    // Memory strobe and read answer
    // ****************************************
    // R16 registers read back only fill
    wire logic       fill_rd = (mem_q.target == DSBD_TGT_NONE)
                            || (mem_q.target == DSBD_TGT_REG);
    wire logic [7:0] rd_data = fill_rd ? `DSBD_RD_FILL : mem_rdata_i;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mem_q     <= '0;
            rd_pend_q <= 1'b0;
            rsp_q     <= '0;
        end else begin
            mem_q       <= mem_d;
            rd_pend_q   <= taken && !req_i.write;
            rsp_q.valid <= rd_pend_q;
            rsp_q.rdata <= rd_pend_q ? rd_data : 8'h00;
        end
    end

    // ****************************************
    // Program fetch
    // ****************************************
    dsbd_prog_map u_map (
        .pc_i    (pc_i),
        .page_i  (page_q),
        .fetch_o (fetch_map)
    );

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fetch_q <= '0;
        end else begin
            fetch_q       <= fetch_map;
            fetch_q.valid <= fetch_valid_i;
        end
    end

    assign mem_o   = mem_q;
    assign rsp_o   = rsp_q;
    assign fetch_o = fetch_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    property win_map_p;
        req_i.valid && !req_i.write && req_i.addr[7:6] == 2'b01
        |=> mem_o.target == DSBD_TGT_ROM && !mem_o.we
            && mem_o.addr == {win_q, $past(req_i.addr[5:0])};
    endproperty
    window_rom_map_a: assert property (win_map_p) // R5 R6
        else $error("window read not mapped to ROM");

    window_reg_load_a: assert property ( // R7
        req_i.valid && req_i.write && !req_i.bitop
        && req_i.addr == 8'hC9 |=> win_q == $past(req_i.wdata))
        else $error("window register not loaded");

    bitop_ignored_a: assert property ( // R16
        req_i.valid && req_i.bitop && !(req_i.write && !req_i.bitop)
        |=> $stable(win_q) && $stable(bank_q) && $stable(page_q))
        else $error("bit operation changed a register");

    direct_ram_map_a: assert property ( // R10
        req_i.valid && req_i.addr[7:6] == 2'b10
        |=> mem_o.target == DSBD_TGT_RAM
            && mem_o.addr == {8'd0, $past(req_i.addr[5:0])})
        else $error("direct RAM mis-mapped");

    eep_page_a: assert property ( // R12
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q == 8'h83
        |=> mem_o.target == DSBD_TGT_EEP && mem_o.addr[8:6] == 3'd5)
        else $error("EEPROM page 5 not selected");

    ram_page_a: assert property ( // R13
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q == 8'h10
        |=> mem_o.target == DSBD_TGT_RAM && mem_o.addr[8:6] == 3'd3)
        else $error("RAM page 4 not selected");

    osd_page_a: assert property ( // R14
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q == 8'h40
        |=> mem_o.target == DSBD_TGT_OSD && mem_o.addr[8:6] == 3'd1)
        else $error("OSD page 6 not selected");

    no_bank_safe_a: assert property ( // R18
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q == 8'h00
        |=> mem_o.target == DSBD_TGT_NONE && !mem_o.we)
        else $error("banked access with no bank reached memory");

    read_answer_a: assert property ( // R4
        req_i.valid && !req_i.write |=> ##1 rsp_o.valid)
        else $error("read answer not two cycles later");

    static_fetch_a: assert property ( // R17
        fetch_valid_i && pc_i[11]
        |=> fetch_o.valid && fetch_o.addr[15:11] == 5'h01)
        else $error("static fetch left page 1");

    reset_vector_a: assert property ( // R1
        fetch_valid_i && pc_i >= 12'hFFE
        |=> fetch_o.region == DSBD_PR_RESET)
        else $error("reset vector misclassed");

    page0_rsv_a: assert property ( // R3
        fetch_valid_i && !pc_i[11] && page_q == 5'h00 && pc_i[10:7] == 4'h0
        |=> fetch_o.region == DSBD_PR_RSV)
        else $error("page 0 reserved area misclassed");

    pagen_user_a: assert property ( // R2
        fetch_valid_i && !pc_i[11] && page_q >= 5'h02 && pc_i[10:4] != 7'h0
        |=> fetch_o.region == DSBD_PR_USER)
        else $error("high page user area misclassed");

    cov_window_c: cover property (
        req_i.valid && req_i.write && req_i.addr == 8'hC9
        ##1 req_i.valid && req_i.addr[7:6] == 2'b01);
    cov_eep_c: cover property (
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q[1:0] != 2'b00);
    cov_osd_c: cover property (
        req_i.valid && req_i.addr[7:6] == 2'b00 && bank_q[6:5] != 2'b00);
    cov_bank_fetch_c: cover property (fetch_valid_i && !pc_i[11]
        && page_q > 5'h01);

endmodule : dsbd_decoder

// ==== dsbd_regs.svh ====
// Constants of the data space bank decoder: offsets, fields, reset values.
// Assumes an 8-bit data space driven by one core on one clock.
//
// What this block does
// R1 - Static page: user code to 0F9Fh, vectors 0FF0-0FF7h, 0FFC-0FFDh, 0FFE-0FFFh.
// R2 - Pages 2 and above: 0000h-000Fh reserved, 0010h-07FFh user code.
// R3 - Page 0: 0000h-007Fh reserved, 0080h-07FFh user code.
// R4 - One data space reaches RAM, EEPROM, core registers and ROM constants.
// R5 - Reads at 40h-7Fh return program ROM bytes through a 64-byte window.
// R6 - ROM address is window register over the six low address bits.
// R7 - Window register is write-only at C9h; each step moves 64 bytes.
// R8 - Window register is eight bits, upper ROM bits, undefined after reset.
// R9 - The window never reaches beyond the 16 kilobyte ROM range.
// R10 - Addresses 80h-BFh map 64 bytes of RAM directly, no banking.
// R11 - Addresses 00h-3Fh reach the bank chosen by the register at E8h.
// R12 - Bank bits 7,1,0 pick EEPROM pages: 01h-03h pages 0-2, 81h-83h 3-5.
// R13 - Bank values 04h, 08h, 10h select RAM pages 2, 3, 4.
// R14 - Bank values 20h and 40h select OSD pages 5 and 6.
// R15 - Software sets one bank at a time and loads it before use.
// R16 - Bank and window registers take whole-byte writes only; reads hold nothing.
// R17 - Top program counter bit set fetches static page, else page register.
// R18 - No bank bit set: banked accesses change nothing, reads unspecified.
`ifndef DSBD_REGS_SVH
`define DSBD_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DSBD_WIN_ADDR   8'hC9
`define DSBD_BANK_ADDR  8'hE8
`define DSBD_PAGE_ADDR  8'hCA

// ****************************************
// Reset values and read fill
// ****************************************
`define DSBD_WIN_RST    8'h00
`define DSBD_BANK_RST   8'h00
`define DSBD_PAGE_RST   5'h00
`define DSBD_RD_FILL    8'hFF

// ****************************************
// Data space regions, by address bits 7:6
// ****************************************
`define DSBD_RGN_BANK   2'b00
`define DSBD_RGN_WIN    2'b01
`define DSBD_RGN_RAM    2'b10

// ****************************************
// Bank register fields
// ****************************************
`define DSBD_BK_EEP_HI  7
`define DSBD_BK_OSD6    6
`define DSBD_BK_OSD5    5
`define DSBD_BK_RAM4    4
`define DSBD_BK_RAM3    3
`define DSBD_BK_RAM2    2

// ****************************************
// Program space map
// ****************************************
`define DSBD_STATIC_PAGE 5'h01
`define DSBD_P0_RSV_END  11'h07F
`define DSBD_PN_RSV_END  11'h00F
`define DSBD_USER_END    12'hF9F
`define DSBD_IRQ_LO      12'hFF0
`define DSBD_IRQ_HI      12'hFF7
`define DSBD_NMI_LO      12'hFFC
`define DSBD_NMI_HI      12'hFFD
`define DSBD_RST_LO      12'hFFE

`endif

// ==== dsbd_pkg.sv ====
// Types of the data space bank decoder.
// Assumes dsbd_regs.svh holds the numbers.
package dsbd_pkg;

    typedef enum logic [2:0] {
        DSBD_TGT_NONE, DSBD_TGT_RAM, DSBD_TGT_EEP, DSBD_TGT_OSD,
        DSBD_TGT_ROM, DSBD_TGT_PER, DSBD_TGT_REG
    } dsbd_target_t;

    typedef enum logic [2:0] {
        DSBD_PR_RSV, DSBD_PR_USER, DSBD_PR_IRQ, DSBD_PR_NMI, DSBD_PR_RESET
    } dsbd_region_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bitop;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsbd_req_t;

    typedef struct packed {
        dsbd_target_t target;
        logic         we;
        logic [13:0]  addr;
        logic [7:0]   wdata;
    } dsbd_mem_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } dsbd_rsp_t;

    typedef struct packed {
        logic         valid;
        logic [15:0]  addr;
        dsbd_region_t region;
    } dsbd_fetch_t;

endpackage : dsbd_pkg

// ==== dsbd_prog_map.sv ====
// Program space map: physical fetch address and region class.
// Assumes a registered page select; purely combinational.
`timescale 1ns/100ps
`include "dsbd_regs.svh"
module dsbd_prog_map (
    input  wire logic [11:0]         pc_i,
    input  wire logic [4:0]          page_i,
    output dsbd_pkg::dsbd_fetch_t    fetch_o
);
    import dsbd_pkg::*;

    // ****************************************
    // Region classes
    // ****************************************
    // R1 static page map
    function automatic dsbd_region_t static_rgn(input logic [11:0] a);
        if (a <= `DSBD_USER_END) begin
            static_rgn = DSBD_PR_USER;
        end else if (a >= `DSBD_IRQ_LO && a <= `DSBD_IRQ_HI) begin
            static_rgn = DSBD_PR_IRQ;
        end else if (a >= `DSBD_NMI_LO && a <= `DSBD_NMI_HI) begin
            static_rgn = DSBD_PR_NMI;
        end else if (a >= `DSBD_RST_LO) begin
            static_rgn = DSBD_PR_RESET;
        end else begin
            static_rgn = DSBD_PR_RSV;
        end
    endfunction : static_rgn

    wire logic         top_bit   = pc_i[11];
    wire logic [10:0]  offset    = pc_i[10:0];
    // R17 static page wins
    wire logic [4:0]   eff_page  = top_bit ? `DSBD_STATIC_PAGE : page_i;
    wire logic         is_static = (eff_page == `DSBD_STATIC_PAGE);
    wire logic         is_page0  = (eff_page == 5'h00);
    // R3 page zero reserved
    wire dsbd_region_t p0_rgn    = (offset <= `DSBD_P0_RSV_END)
                                   ? DSBD_PR_RSV : DSBD_PR_USER;
    // R2 higher pages reserved
    wire dsbd_region_t pn_rgn    = (offset <= `DSBD_PN_RSV_END)
                                   ? DSBD_PR_RSV : DSBD_PR_USER;

    // Page 1 in the lower half is the static page seen twice
    assign fetch_o.valid  = 1'b1;
    assign fetch_o.addr   = {eff_page, offset};
    assign fetch_o.region = is_static ? static_rgn({1'b1, offset})
                          : is_page0  ? p0_rgn : pn_rgn;

endmodule : dsbd_prog_map

// ==== dsbd_mem_model.sv ====
// Memory side model: ROM, RAM, EEPROM, OSD and registers in one.
// Assumes mem_o of the decoder; answers at once, no wait states.
`timescale 1ns/100ps
module dsbd_mem_model (
    input  wire logic                clock_i,
    input  wire dsbd_pkg::dsbd_mem_t mem_i,
    output logic [7:0]               rdata_o
);
    import dsbd_pkg::*;
    logic [7:0] junk_q = 8'hA5;

    // ****************************************
    // Read data
    // ****************************************
    // Unselected bus flips between A5h and 5Bh every cycle, so a byte one cycle stale never matches
    always_ff @(posedge clock_i) begin
        junk_q <= ~junk_q + 8'h01;
    end
    assign rdata_o = (mem_i.target == DSBD_TGT_NONE) ? junk_q :
        mem_i.addr[7:0] ^ mem_i.addr[13:6] ^ {5'h00, mem_i.target};
endmodule : dsbd_mem_model

// ==== test_data_space_bank_decoder.sv ====
// Self-checking bench of the data space decoder.
// Assumes one clock; requests driven on falling edges.
`timescale 1ns/100ps
`include "dsbd_regs.svh"
module test_data_space_bank_decoder;
    import dsbd_pkg::*;
    logic        clock_i       = 1'b0;
    logic        reset_i       = 1'b1;
    dsbd_req_t   req_i         = '0;
    logic        fetch_valid_i = 1'b0;
    logic [11:0] pc_i          = 12'h000;
    logic [7:0]  mem_rdata;
    dsbd_mem_t   mem_o;
    dsbd_rsp_t   rsp_o;
    dsbd_fetch_t fetch_o;
    dsbd_mem_t   m_seen;
    dsbd_rsp_t   r_seen;
    int          n_errors      = 0;
    int          n_compared    = 0;
    int          n_cycles      = 0;
    logic [7:0]   codes [11] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82,
        8'h83, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    dsbd_target_t tgts [11] = '{DSBD_TGT_EEP, DSBD_TGT_EEP, DSBD_TGT_EEP,
        DSBD_TGT_EEP, DSBD_TGT_EEP, DSBD_TGT_EEP, DSBD_TGT_RAM,
        DSBD_TGT_RAM, DSBD_TGT_RAM, DSBD_TGT_OSD, DSBD_TGT_OSD};
    logic [13:0]  bases [11] = '{14'h0000, 14'h0040, 14'h0080, 14'h00C0,
        14'h0100, 14'h0140, 14'h0040, 14'h0080, 14'h00C0, 14'h0000,
        14'h0040};

    always #4 clock_i = ~clock_i;

    dsbd_decoder dsbd_decoder_i (
        .clock_i       (clock_i),
        .reset_i       (reset_i),
        .req_i         (req_i),
        .fetch_valid_i (fetch_valid_i),
        .pc_i          (pc_i),
        .mem_rdata_i   (mem_rdata),
        .mem_o         (mem_o),
        .rsp_o         (rsp_o),
        .fetch_o       (fetch_o)
    );
    dsbd_mem_model dsbd_mem_model_i (
        .clock_i (clock_i),
        .mem_i   (mem_o),
        .rdata_o (mem_rdata)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task print_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One request, then idle; mem_o and rsp_o caught where settled
    task acc(input logic w, input logic b, input logic [7:0] a,
             input logic [7:0] d);
        req_i = '{1'b1, w, b, a, d};
        @(negedge clock_i);
        m_seen = mem_o;
        req_i = '0;
        @(negedge clock_i);
        r_seen = rsp_o;
    endtask : acc

    function automatic logic [7:0] mdat(input dsbd_target_t t,
                                        input logic [13:0] a);
        return a[7:0] ^ a[13:6] ^ {5'h00, t};
    endfunction : mdat

    task rd(input logic [7:0] a, input dsbd_target_t t,
            input logic [13:0] ea, input logic [7:0] ed);
        acc(1'b0, 1'b0, a, 8'h00);
        chk("rd target", m_seen.target, t);
        chk("rd addr", m_seen.addr, ea);
        chk("rd we", m_seen.we, 1'b0);
        chk("rsp valid", r_seen.valid, 1'b1);
        chk("rsp data", r_seen.rdata, ed);
    endtask : rd

    // Fetch valid is held high by the caller across calls
    task fch(input logic [11:0] pc, input logic [15:0] ea,
             input dsbd_region_t rg);
        pc_i = pc;
        @(negedge clock_i);
        chk("fetch valid", fetch_o.valid, 1'b1);
        chk("fetch addr", fetch_o.addr, ea);
        chk("fetch region", fetch_o.region, rg);
    endtask : fch

    // ****************************************
    // Timeout
    // ****************************************
    always @(posedge clock_i) begin
        n_cycles++;
        if (n_cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge clock_i);
        reset_i = 1'b0;
        chk("reset mem", mem_o, 26'h0);
        chk("reset rsp", rsp_o, 9'h0);
        chk("reset fetch", fetch_o, 20'h0);
        // Window moves and read-only access
        acc(1'b1, 1'b0, `DSBD_WIN_ADDR, 8'h02);
        chk("win wr we", m_seen.we, 1'b1);
        rd(8'h45, DSBD_TGT_ROM, 14'h0085, mdat(DSBD_TGT_ROM, 14'h0085));
        acc(1'b1, 1'b0, 8'h45, 8'h11);
        chk("rom wr we", m_seen.we, 1'b0);
        acc(1'b1, 1'b1, `DSBD_WIN_ADDR, 8'h07);
        chk("bitop we", m_seen.we, 1'b0);
        rd(8'h40, DSBD_TGT_ROM, 14'h0080, mdat(DSBD_TGT_ROM, 14'h0080));
        rd(`DSBD_WIN_ADDR, DSBD_TGT_REG, 14'h0000, 8'hFF);
        acc(1'b1, 1'b0, `DSBD_WIN_ADDR, 8'hFF);
        rd(8'h7F, DSBD_TGT_ROM, 14'h3FFF, mdat(DSBD_TGT_ROM, 14'h3FFF));
        // Direct RAM and peripherals
        rd(8'h80, DSBD_TGT_RAM, 14'h0000, mdat(DSBD_TGT_RAM, 14'h0000));
        rd(8'hBF, DSBD_TGT_RAM, 14'h003F, mdat(DSBD_TGT_RAM, 14'h003F));
        acc(1'b1, 1'b0, 8'h9A, 8'h33);
        chk("ram wr", {m_seen.we, m_seen.addr, m_seen.wdata}, 23'h401A33);
        rd(8'hC0, DSBD_TGT_PER, 14'h00C0, mdat(DSBD_TGT_PER, 14'h00C0));
        // Every bank code; software loads one code before use
        for (int i = 0; i < 11; i++) begin
            acc(1'b1, 1'b0, `DSBD_BANK_ADDR, codes[i]);
            rd(8'h3F, tgts[i], bases[i] + 14'h3F,
               mdat(tgts[i], bases[i] + 14'h3F));
        end
        acc(1'b1, 1'b0, 8'h00, 8'h5C);
        chk("osd wr", {m_seen.target, m_seen.we, m_seen.addr},
            {DSBD_TGT_OSD, 1'b1, 14'h0040});
        // Empty bank leaves memories untouched
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, 1'b0, `DSBD_BANK_ADDR, i ? 8'h80 : 8'h00);
            acc(1'b1, 1'b0, 8'h10, 8'h77);
            chk("empty wr", {m_seen.target, m_seen.we}, 4'h0);
            acc(1'b0, 1'b0, 8'h10, 8'h00);
            chk("empty rd", r_seen.rdata, 8'hFF);
        end
        // Bank write takes effect for the very next request
        req_i = '{1'b1, 1'b1, 1'b0, `DSBD_BANK_ADDR, 8'h08};
        @(negedge clock_i);
        req_i = '{1'b1, 1'b0, 1'b0, 8'h05, 8'h00};
        @(negedge clock_i);
        req_i = '0;
        chk("b2b mem", {mem_o.target, mem_o.addr},
            {DSBD_TGT_RAM, 14'h0085});
        @(negedge clock_i);
        chk("b2b data", rsp_o.rdata, mdat(DSBD_TGT_RAM, 14'h0085));
        // Program space map
        fetch_valid_i = 1'b1;
        fch(12'hFFE, 16'h0FFE, DSBD_PR_RESET);
        fch(12'hFFD, 16'h0FFD, DSBD_PR_NMI);
        fch(12'hFF7, 16'h0FF7, DSBD_PR_IRQ);
        fch(12'hFF0, 16'h0FF0, DSBD_PR_IRQ);
        fch(12'hF9F, 16'h0F9F, DSBD_PR_USER);
        fch(12'hFA0, 16'h0FA0, DSBD_PR_RSV);
        acc(1'b1, 1'b0, `DSBD_PAGE_ADDR, 8'h00);
        fch(12'h07F, 16'h007F, DSBD_PR_RSV);
        fch(12'h080, 16'h0080, DSBD_PR_USER);
        acc(1'b1, 1'b0, `DSBD_PAGE_ADDR, 8'h03);
        fch(12'h00F, 16'h180F, DSBD_PR_RSV);
        fch(12'h010, 16'h1810, DSBD_PR_USER);
        fch(12'hFFE, 16'h0FFE, DSBD_PR_RESET);
        // Page 1 in the lower half is the static page again
        acc(1'b1, 1'b0, `DSBD_PAGE_ADDR, 8'h01);
        fch(12'h7FE, 16'h0FFE, DSBD_PR_RESET);
        fetch_valid_i = 1'b0;
        @(negedge clock_i);
        chk("fetch idle", fetch_o.valid, 1'b0);
        print_verdict();
    end
endmodule : test_data_space_bank_decoder
